// >>> hw/gss_pkg.sv
/*
  Package for the gas sensor supervisor: register map, error byte layout,
  thresholds, output scaling and timing counts.
  Assumes a 10 MHz system clock and concentrations given in whole ppm.
*/
package gss_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned HOLD_TIME_S   = 8;
  localparam int unsigned HOLD_CYCLES   = HOLD_TIME_S * CLK_HZ;
  localparam int unsigned ABC_PERIOD_MH = 180;  // 7.5 days in hours
  localparam longint unsigned ABC_CYCLES =
    longint'(ABC_PERIOD_MH) * 64'd3600 * longint'(CLK_HZ);
  localparam int unsigned SELFTEST_CYCLES = 16;

  // ---------------------------------------------------------------------
  // Concentration figures in ppm
  // ---------------------------------------------------------------------
  localparam logic [15:0] FULL_SCALE_PPM = 16'd2000;
  localparam logic [15:0] LOW_ALM_LO     = 16'd700;
  localparam logic [15:0] LOW_ALM_HI     = 16'd800;
  localparam logic [15:0] HIGH_ALM_LO    = 16'd900;
  localparam logic [15:0] HIGH_ALM_HI    = 16'd1000;
  localparam logic [15:0] FRESH_AIR_PPM  = 16'd400;
  localparam logic [15:0] ZERO_GAS_PPM   = 16'd0;
  localparam logic [15:0] ABC_STEP_PPM   = 16'd30;
  localparam logic [15:0] MAX_VALID_PPM  = 16'd10000;

  // ---------------------------------------------------------------------
  // Analogue output codes in millivolts
  // ---------------------------------------------------------------------
  localparam logic [15:0] OVW_MV_LO = 16'd0;
  localparam logic [15:0] OVW_MV_HI = 16'd4000;
  localparam logic [15:0] PRC_MV_LO = 16'd1000;
  localparam logic [15:0] PRC_MV_HI = 16'd5000;

  // ---------------------------------------------------------------------
  // Error byte bits
  // ---------------------------------------------------------------------
  localparam int ERR_FATAL  = 0;
  localparam int ERR_OFFSET = 1;
  localparam int ERR_ALGO   = 2;
  localparam int ERR_OUTPUT = 3;
  localparam int ERR_SELF   = 4;
  localparam int ERR_RANGE  = 5;
  localparam int ERR_MEMORY = 6;
  localparam logic [7:0] ERR_AUTO_MASK = 8'h22;
  localparam logic [7:0] ERR_USED_MASK = 8'h7F;

  // ---------------------------------------------------------------------
  // Register map (word addresses on the plain port)
  // ---------------------------------------------------------------------
  localparam logic [3:0] REG_CONC      = 4'h0;
  localparam logic [3:0] REG_RAW       = 4'h1;
  localparam logic [3:0] REG_ZERO      = 4'h2;
  localparam logic [3:0] REG_FRESH_REF = 4'h3;
  localparam logic [3:0] REG_ERROR     = 4'h4;
  localparam logic [3:0] REG_OVW_OUT   = 4'h5;
  localparam logic [3:0] REG_PRC_OUT   = 4'h6;
  localparam logic [3:0] REG_STATUS    = 4'h7;
  localparam logic [3:0] REG_NVM_DATA  = 4'h8;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } gss_bus_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } gss_meas_s;

  typedef enum logic [1:0] {GSS_SELFTEST, GSS_RUN, GSS_NVM_CHECK} gss_state_e;

endpackage : gss_pkg

// >>> hw/gss_supervisor.sv
/*
  Gas sensor supervisor: output scaling, alarms with hysteresis, trim switch
  qualification and recalibration, baseline drift correction, error byte.
  Assumes synchronous inputs, one 10 MHz clock, and a nonvolatile store
  that answers a write with a read-back word any number of cycles later.
*/
// What this block does
// - Overview output maps 0-2000 ppm to 0-4 V
// - Precise output maps 0-2000 ppm to 1-5 V
// - Low alarm hysteresis 700/800 ppm
// - High alarm hysteresis 900/1000 ppm
// - Fresh-air switch held 8 s recalibrates
// - Zero-gas switch held 8 s recalibrates
// - Recalibration makes reading equal reference value
// - Recalibration repeats while switch stays closed
// - Fresh-air reference 400 ppm, host writable
// - Baseline correction tracks minimum per period
// - Baseline step limited to 30 ppm
// - Self-test runs after every power-up
// - Out-of-range measurement flags an error
// - Memory write verified by read-back compare
// - Status low while error byte nonzero
// - Host can read full error byte
// - Offset and range bits clear themselves
// - Other bits sticky until host overwrite
// - Serial side exposes precise concentration, status
// - Error byte bit assignment as listed
// - Several faults combine into one value
`timescale 1ns/100ps
`default_nettype none

module gss_supervisor
  import gss_pkg::*;
#(
  parameter int unsigned  HOLD_CNT = HOLD_CYCLES,
  parameter longint unsigned ABC_CNT = ABC_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Measurement from the sensing front end
  input  wire gss_meas_s   meas,
  input  wire logic        offset_fault,
  input  wire logic        selftest_fail,
  // Trim switches, low when closed
  input  wire logic        fresh_air_trim_switch,
  input  wire logic        zero_gas_trim_switch,
  // Nonvolatile store port
  output logic             nvm_wr,
  output logic [15:0]      nvm_wdata,
  input  wire logic        nvm_rvalid,
  input  wire logic [15:0] nvm_rdata,
  // Register port
  input  wire gss_bus_s    bus,
  output logic [15:0]      rdata,
  // Outputs
  output logic [15:0]      overview_analog_output,
  output logic [15:0]      precise_analog_output,
  output logic             low_alarm_output,
  output logic             high_alarm_output,
  output logic             status_ok
);

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  function automatic logic [15:0] scale_mv(input logic [15:0] ppm,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
    logic [31:0] c;
    logic [31:0] p;
    c = (ppm > FULL_SCALE_PPM) ? 32'(FULL_SCALE_PPM) : 32'(ppm);
    p = c * 32'(hi - lo) / 32'(FULL_SCALE_PPM);
    return 16'(p + 32'(lo));
  endfunction : scale_mv

  function automatic logic [31:0] sat_add(input logic [31:0] hold);
    return (hold == 32'hFFFF_FFFF) ? hold : hold + 32'h1;
  endfunction : sat_add

  // -----------------------------------------------------------------------
  // Power-up self-test and sequencing
  // -----------------------------------------------------------------------
  gss_state_e  state_q;
  logic [4:0]  st_cnt_q;
  logic [15:0] raw_q;
  logic [15:0] zero_q;
  logic [15:0] fresh_ref_q;
  logic [15:0] conc_q;
  logic [15:0] conc_d;
  logic [7:0]  err_q;
  logic        range_bad;
  logic        req_fresh;
  logic        req_zero;
  logic        cal_pulse;
  logic        abc_pulse;
  logic [15:0] new_zero;
  logic        nvm_mismatch;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q  <= GSS_SELFTEST;
      st_cnt_q <= 5'h00;
    end else begin
      case (state_q)
        GSS_SELFTEST: begin
          st_cnt_q <= st_cnt_q + 5'h01;
          if (st_cnt_q == 5'(SELFTEST_CYCLES - 1)) begin
            state_q <= GSS_RUN;
          end
        end
        GSS_RUN: begin
          if (nvm_wr) begin
            state_q <= GSS_NVM_CHECK;
          end
        end
        GSS_NVM_CHECK: begin
          if (nvm_rvalid) begin
            state_q <= GSS_RUN;
          end
        end
        default: state_q <= GSS_SELFTEST;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Concentration
  // -----------------------------------------------------------------------
  // The minimum tracker needs the new reading, not the one it replaces.
  assign conc_d = (meas.data > zero_q) ? meas.data - zero_q : 16'h0000;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      raw_q  <= 16'h0000;
      conc_q <= 16'h0000;
    end else if (meas.valid) begin
      raw_q  <= meas.data;
      conc_q <= conc_d;
    end
  end

  assign range_bad = meas.valid && (meas.data > MAX_VALID_PPM);

  // -----------------------------------------------------------------------
  // Analogue outputs and alarms
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      overview_analog_output <= OVW_MV_LO;
      precise_analog_output  <= PRC_MV_LO;
    end else begin
      overview_analog_output <= scale_mv(conc_q, OVW_MV_LO, OVW_MV_HI);
      precise_analog_output  <= scale_mv(conc_q, PRC_MV_LO, PRC_MV_HI);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      low_alarm_output  <= 1'b0;
      high_alarm_output <= 1'b0;
    end else begin
      if (conc_q >= LOW_ALM_HI) begin
        low_alarm_output <= 1'b1;
      end else if (conc_q < LOW_ALM_LO) begin
        low_alarm_output <= 1'b0;
      end
      if (conc_q >= HIGH_ALM_HI) begin
        high_alarm_output <= 1'b1;
      end else if (conc_q < HIGH_ALM_LO) begin
        high_alarm_output <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Trim switch qualification
  // -----------------------------------------------------------------------
  logic [31:0] fresh_hold_q;
  logic [31:0] zero_hold_q;

  // A grounded pin is a request; any release restarts the count.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fresh_hold_q <= 32'h0;
      zero_hold_q  <= 32'h0;
    end else begin
      fresh_hold_q <= fresh_air_trim_switch ? 32'h0 : sat_add(fresh_hold_q);
      zero_hold_q  <= zero_gas_trim_switch  ? 32'h0 : sat_add(zero_hold_q);
    end
  end

  assign req_fresh = fresh_hold_q >= HOLD_CNT;
  assign req_zero  = zero_hold_q  >= HOLD_CNT;
  // Recalibrate on every new measurement that arrives in the run state while held.
  assign cal_pulse = (state_q == GSS_RUN) && meas.valid && (req_fresh || req_zero);

  // Zero-gas takes priority when both switches are held.
  always_comb begin
    if (req_zero) begin
      new_zero = (meas.data > ZERO_GAS_PPM) ? meas.data - ZERO_GAS_PPM : 16'h0000;
    end else begin
      new_zero = (meas.data > fresh_ref_q) ? meas.data - fresh_ref_q : 16'h0000;
    end
  end

  // -----------------------------------------------------------------------
  // Baseline drift correction
  // -----------------------------------------------------------------------
  logic [63:0] abc_cnt_q;
  logic [15:0] min_q;
  logic [15:0] abc_zero;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      abc_cnt_q <= 64'h0;
      min_q     <= 16'hFFFF;
    end else if (abc_pulse) begin
      abc_cnt_q <= 64'h0;
      min_q     <= 16'hFFFF;
    end else begin
      abc_cnt_q <= abc_cnt_q + 64'h1;
      if (meas.valid && (conc_d < min_q)) begin
        min_q <= conc_d;
      end
    end
  end

  assign abc_pulse = (abc_cnt_q == ABC_CNT - 64'h1);

  // Move zero so the period minimum drifts toward fresh air, 30 ppm at most.
  always_comb begin
    abc_zero = zero_q;
    if (min_q != 16'hFFFF) begin
      if (min_q > FRESH_AIR_PPM + ABC_STEP_PPM) begin
        abc_zero = zero_q + ABC_STEP_PPM;
      end else if (min_q > FRESH_AIR_PPM) begin
        abc_zero = zero_q + (min_q - FRESH_AIR_PPM);
      end else if (FRESH_AIR_PPM - min_q > ABC_STEP_PPM) begin
        abc_zero = (zero_q > ABC_STEP_PPM) ? zero_q - ABC_STEP_PPM : 16'h0000;
      end else begin
        abc_zero = (zero_q > FRESH_AIR_PPM - min_q) ? zero_q - (FRESH_AIR_PPM - min_q) : 16'h0000;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Zero constant and nonvolatile write with read-back
  // -----------------------------------------------------------------------
  logic host_zero_wr;
  assign host_zero_wr = bus.wr && (bus.addr == REG_ZERO);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      zero_q    <= 16'h0000;
      nvm_wr    <= 1'b0;
      nvm_wdata <= 16'h0000;
    end else begin
      nvm_wr <= 1'b0;
      if (state_q == GSS_RUN && !nvm_wr) begin
        if (cal_pulse) begin
          zero_q    <= new_zero;
          nvm_wr    <= 1'b1;
          nvm_wdata <= new_zero;
        end else if (abc_pulse) begin
          zero_q    <= abc_zero;
          nvm_wr    <= 1'b1;
          nvm_wdata <= abc_zero;
        end else if (host_zero_wr) begin
          zero_q    <= bus.wdata;
          nvm_wr    <= 1'b1;
          nvm_wdata <= bus.wdata;
        end
      end
    end
  end

  assign nvm_mismatch = (state_q == GSS_NVM_CHECK) && nvm_rvalid && (nvm_rdata != nvm_wdata);

  // -----------------------------------------------------------------------
  // Fresh-air reference
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fresh_ref_q <= FRESH_AIR_PPM;
    end else if (bus.wr && (bus.addr == REG_FRESH_REF)) begin
      fresh_ref_q <= bus.wdata;
    end
  end

  // -----------------------------------------------------------------------
  // Error byte
  // -----------------------------------------------------------------------
  logic [7:0] err_set;
  logic [7:0] err_d;

  always_comb begin
    err_set             = 8'h00;
    err_set[ERR_FATAL]  = (state_q == GSS_SELFTEST) && selftest_fail;
    err_set[ERR_OFFSET] = offset_fault;
    err_set[ERR_SELF]   = (state_q == GSS_SELFTEST) && selftest_fail;
    err_set[ERR_RANGE]  = range_bad;
    err_set[ERR_MEMORY] = nvm_mismatch;
    // Sticky bits keep their value unless overwritten; set wins the overwrite.
    err_d = err_q & ~ERR_AUTO_MASK;
    if (bus.wr && (bus.addr == REG_ERROR)) begin
      err_d = bus.wdata[7:0] & ~ERR_AUTO_MASK;
    end
    err_d = (err_d | err_set) & ERR_USED_MASK;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      err_q <= 8'h00;
    end else begin
      err_q <= err_d;
    end
  end

  assign status_ok = (err_q == 8'h00);

  // -----------------------------------------------------------------------
  // Register read port
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else if (bus.rd) begin
      if (bus.addr == REG_CONC) begin
        rdata <= conc_q;
      end else if (bus.addr == REG_RAW) begin
        rdata <= raw_q;
      end else if (bus.addr == REG_ZERO) begin
        rdata <= zero_q;
      end else if (bus.addr == REG_FRESH_REF) begin
        rdata <= fresh_ref_q;
      end else if (bus.addr == REG_ERROR) begin
        rdata <= {8'h00, err_q};
      end else if (bus.addr == REG_OVW_OUT) begin
        rdata <= overview_analog_output;
      end else if (bus.addr == REG_PRC_OUT) begin
        rdata <= precise_analog_output;
      end else if (bus.addr == REG_STATUS) begin
        rdata <= {10'h000, req_zero, req_fresh, high_alarm_output, low_alarm_output,
                  2'(state_q)};
      end else if (bus.addr == REG_NVM_DATA) begin
        rdata <= nvm_wdata;
      end else begin
        rdata <= 16'h0000;
      end
    end else begin
      rdata <= 16'h0000;
    end
  end

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  property p_low_alarm_set;
    @(posedge mclk) disable iff (!rst_b)
      (conc_q >= LOW_ALM_HI) |=> low_alarm_output;
  endproperty
  a_low_alarm_set: assert property (p_low_alarm_set) else $error("low alarm not set");

  property p_high_alarm_hold;
    @(posedge mclk) disable iff (!rst_b)
      (high_alarm_output && conc_q >= HIGH_ALM_LO) |=> high_alarm_output;
  endproperty
  a_high_alarm_hold: assert property (p_high_alarm_hold) else $error("high alarm dropped");

  property p_status;
    @(posedge mclk) disable iff (!rst_b)
      (err_set != 8'h00) |=> !status_ok;
  endproperty
  a_status: assert property (p_status) else $error("status disagrees with error byte");

  property p_release_restart;
    @(posedge mclk) disable iff (!rst_b)
      fresh_air_trim_switch |=> (fresh_hold_q == 32'h0) && !req_fresh;
  endproperty
  a_release_restart: assert property (p_release_restart) else $error("hold not restarted");

  property p_memory_sticky;
    @(posedge mclk) disable iff (!rst_b)
      (err_q[ERR_MEMORY] && !(bus.wr && bus.addr == REG_ERROR)) |=> err_q[ERR_MEMORY];
  endproperty
  a_memory_sticky: assert property (p_memory_sticky) else $error("memory bit lost");

  property p_range_clears;
    @(posedge mclk) disable iff (!rst_b)
      !range_bad |=> !err_q[ERR_RANGE];
  endproperty
  a_range_clears: assert property (p_range_clears) else $error("range bit stuck");

  property p_mismatch_flag;
    @(posedge mclk) disable iff (!rst_b)
      nvm_mismatch |=> err_q[ERR_MEMORY];
  endproperty
  a_mismatch_flag: assert property (p_mismatch_flag) else $error("mismatch not flagged");

  property p_cal_zero;
    @(posedge mclk) disable iff (!rst_b)
      (cal_pulse && !nvm_wr) |=> (zero_q == $past(new_zero)) && nvm_wr;
  endproperty
  a_cal_zero: assert property (p_cal_zero) else $error("zero not replaced");

endmodule : gss_supervisor

`default_nettype wire

// >>> tb/gss_nvm_model.sv
/*
  Nonvolatile store model that answers each write with a read-back word.
  Assumes one write at a time; slow adds latency, corrupt spoils the word.
*/
`timescale 1ns/100ps
`default_nettype none

module gss_nvm_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Store port
  input  wire logic        nvm_wr,
  input  wire logic [15:0] nvm_wdata,
  output logic             nvm_rvalid,
  output logic [15:0]      nvm_rdata,
  // Test controls
  input  wire logic        slow,
  input  wire logic        corrupt
);
  logic [15:0] mem_q;
  logic [3:0]  wait_q;
  logic        busy_q;

  // Outside a reply the read-back lines toggle, so stale data never looks valid.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem_q      <= 16'h0000;
      wait_q     <= 4'h0;
      busy_q     <= 1'b0;
      nvm_rvalid <= 1'b0;
      nvm_rdata  <= 16'hA5A5;
    end else begin
      nvm_rvalid <= 1'b0;
      nvm_rdata  <= ~nvm_rdata;
      if (nvm_wr) begin
        mem_q  <= corrupt ? ~nvm_wdata : nvm_wdata;
        busy_q <= 1'b1;
        wait_q <= slow ? 4'h6 : 4'h0;
      end else if (busy_q && wait_q == 4'h0) begin
        nvm_rvalid <= 1'b1;
        nvm_rdata  <= mem_q;
        busy_q     <= 1'b0;
      end else if (busy_q) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule : gss_nvm_model
`default_nettype wire

// >>> tb/tb.sv
/*
  Self-checking testbench for the gas sensor supervisor.
  Assumes gss_pkg and gss_nvm_model are compiled first; short hold and period counts.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  import gss_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  gss_meas_s   meas = '0;
  gss_bus_s    bus = '0;
  logic        offset_fault = 1'b0;
  logic        selftest_fail = 1'b0;
  logic        fresh_sw = 1'b1;
  logic        zero_sw = 1'b1;
  logic        slow = 1'b0;
  logic        corrupt = 1'b0;
  logic        nvm_wr, nvm_rvalid, low_alm, high_alm, status_ok;
  logic [15:0] nvm_wdata, nvm_rdata, rdata, ovw, prc;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  always #50 mclk = ~mclk;

  gss_supervisor #(.HOLD_CNT(20), .ABC_CNT(64'd1000)) uut (
    .mclk(mclk), .rst_b(rst_b), .meas(meas), .offset_fault(offset_fault),
    .selftest_fail(selftest_fail), .fresh_air_trim_switch(fresh_sw),
    .zero_gas_trim_switch(zero_sw), .nvm_wr(nvm_wr), .nvm_wdata(nvm_wdata),
    .nvm_rvalid(nvm_rvalid), .nvm_rdata(nvm_rdata), .bus(bus), .rdata(rdata),
    .overview_analog_output(ovw), .precise_analog_output(prc),
    .low_alarm_output(low_alm), .high_alarm_output(high_alm), .status_ok(status_ok));

  gss_nvm_model store (
    .mclk(mclk), .rst_b(rst_b), .nvm_wr(nvm_wr), .nvm_wdata(nvm_wdata),
    .nvm_rvalid(nvm_rvalid), .nvm_rdata(nvm_rdata), .slow(slow), .corrupt(corrupt));

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic stop_test();
    $display("Counts: %0d mismatches in %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic do_reset(input logic fail);
    @(posedge mclk);
    rst_b         <= 1'b0;
    selftest_fail <= fail;
    cyc(8);
    rst_b <= 1'b1;
    cyc(20);
    selftest_fail <= 1'b0;
  endtask : do_reset

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1;
    chk_word(rdata, exp, what);
  endtask : rd

  task automatic sample(input logic [15:0] d);
    @(posedge mclk);
    meas <= '{valid: 1'b1, data: d};
    @(posedge mclk);
    meas.valid <= 1'b0;
    cyc(4);
    #1;
  endtask : sample

  task automatic wait_nvm();
    int i;
    for (i = 0; i < 50; i++) begin
      #1;
      if (nvm_wr === 1'b1) break;
      @(posedge mclk);
    end
    if (i == 50) begin
      n_mismatch++;
      $display("Error at %0t: store write never came", $time);
      stop_test();
    end
  endtask : wait_nvm

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_selftest();
    do_reset(1'b1);
    rd(REG_ERROR, 16'h0011, "selftest error byte");
    chk_bit(status_ok, 1'b0, "status on fault");
    wr(REG_ERROR, 16'h0000);
    rd(REG_ERROR, 16'h0000, "error after overwrite");
    chk_bit(status_ok, 1'b1, "status when clear");
    rd(REG_FRESH_REF, 16'd400, "fresh reference reset");
    rd(4'hF, 16'h0000, "unmapped read");
    $display("test selftest finished");
  endtask : t_selftest

  task automatic t_outputs();
    logic [15:0] v[5] = '{16'd0, 16'd1, 16'd1000, 16'd2000, 16'd3000};
    logic [15:0] e;
    wr(REG_ZERO, 16'd0);
    cyc(10);
    foreach (v[i]) begin
      sample(v[i]);
      e = (v[i] > 16'd2000) ? 16'd2000 : v[i];
      chk_word(ovw, e * 16'd2, "overview code");
      chk_word(prc, e * 16'd2 + 16'd1000, "precise code");
      rd(REG_CONC, v[i], "serial concentration");
    end
    wr(REG_CONC, 16'h1234);
    rd(REG_CONC, 16'd3000, "read-only concentration");
    rd(REG_RAW, 16'd3000, "raw reading");
    rd(REG_OVW_OUT, 16'd4000, "overview code word");
    rd(REG_PRC_OUT, 16'd5000, "precise code word");
    $display("test outputs finished");
  endtask : t_outputs

  task automatic t_alarms();
    logic [15:0] v[9] = '{799, 800, 700, 699, 999, 1000, 900, 899, 0};
    logic lo_e[9] = '{0, 1, 1, 0, 1, 1, 1, 1, 0};
    logic hi_e[9] = '{0, 0, 0, 0, 0, 1, 1, 0, 0};
    sample(16'd0);
    foreach (v[i]) begin
      sample(v[i]);
      chk_bit(low_alm, lo_e[i], "low alarm");
      chk_bit(high_alm, hi_e[i], "high alarm");
    end
    rd(REG_STATUS, 16'h0001, "status word");
    $display("test alarms finished");
  endtask : t_alarms

  task automatic t_errors();
    @(posedge mclk);
    offset_fault <= 1'b1;
    meas         <= '{valid: 1'b1, data: 16'd10001};
    @(posedge mclk);
    meas.valid <= 1'b0;
    bus        <= '{addr: REG_ERROR, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1;
    chk_word(rdata, 16'h0022, "combined faults");
    chk_bit(status_ok, 1'b0, "status on range fault");
    @(posedge mclk);
    offset_fault <= 1'b0;
    sample(16'd500);
    rd(REG_ERROR, 16'h0000, "self-clearing bits");
    $display("test errors finished");
  endtask : t_errors

  task automatic t_switch();
    slow <= 1'b1;
    wr(REG_ZERO, 16'd0);
    cyc(10);
    fresh_sw <= 1'b0;
    cyc(15);
    fresh_sw <= 1'b1;
    @(posedge mclk);
    fresh_sw <= 1'b0;
    cyc(14);
    sample(16'd500);
    rd(REG_ZERO, 16'd0, "short closure ignored");
    sample(16'd500);
    rd(REG_ZERO, 16'd100, "fresh-air zero");
    cyc(8);
    sample(16'd600);
    rd(REG_ZERO, 16'd200, "repeated while closed");
    fresh_sw <= 1'b1;
    sample(16'd600);
    rd(REG_CONC, 16'd400, "reading at reference");
    zero_sw <= 1'b0;
    cyc(25);
    sample(16'd300);
    zero_sw <= 1'b1;
    rd(REG_ZERO, 16'd300, "zero-gas zero");
    wr(REG_FRESH_REF, 16'd500);
    rd(REG_FRESH_REF, 16'd500, "fresh reference write");
    fresh_sw <= 1'b0;
    cyc(25);
    sample(16'd900);
    fresh_sw <= 1'b1;
    rd(REG_ZERO, 16'd400, "zero with new reference");
    $display("test switch finished");
  endtask : t_switch

  task automatic t_nvm();
    cyc(10);
    corrupt <= 1'b1;
    wr(REG_ZERO, 16'd5);
    wait_nvm();
    cyc(12);
    rd(REG_ERROR, 16'h0040, "memory error");
    rd(REG_NVM_DATA, 16'd5, "store write word");
    corrupt <= 1'b0;
    cyc(20);
    rd(REG_ERROR, 16'h0040, "memory error sticky");
    chk_bit(status_ok, 1'b0, "status on memory fault");
    wr(REG_ERROR, 16'h0000);
    rd(REG_ERROR, 16'h0000, "memory error cleared");
    $display("test nvm finished");
  endtask : t_nvm

  task automatic t_abc();
    do_reset(1'b0);
    wr(REG_ZERO, 16'd0);
    repeat (170) sample(16'd500);
    rd(REG_ZERO, 16'd30, "baseline step limit");
    $display("test baseline finished");
  endtask : t_abc

  initial begin
    do_reset(1'b0);
    t_selftest();
    t_outputs();
    t_alarms();
    t_errors();
    t_switch();
    t_nvm();
    t_abc();
    stop_test();
  end
endmodule : tb
`default_nettype wire
